// *** rtl/fspc_cfg.svh ***
// Constants for the flash self-program control block.
// Assumes a Wishbone byte-addressed register map with 32-bit data.
`ifndef FSPC_CFG_SVH
`define FSPC_CFG_SVH
`define FSPC_OFF_DATA_LOW   8'h00
`define FSPC_OFF_DATA_HIGH  8'h04
`define FSPC_OFF_ADDR_LOW   8'h08
`define FSPC_OFF_ADDR_HIGH  8'h0C
`define FSPC_OFF_CONTROL    8'h10
`define FSPC_OFF_UNLOCK     8'h14
`define FSPC_BIT_FETCH_GO   0
`define FSPC_BIT_PROG_GO    1
`define FSPC_BIT_PROG_EN    2
`define FSPC_BIT_FAULT      3
`define FSPC_BIT_ERASE_SEL  4
`define FSPC_BIT_LATCH_ONLY 5
`define FSPC_BIT_CFG_SEL    6
`define FSPC_KEY_FIRST      8'h55
`define FSPC_KEY_SECOND     8'hAA
`define FSPC_BLANK_WORD     14'h3FFF
`define FSPC_CFG_USER_LAST  15'h0003
`define FSPC_CFG_REV_ID     15'h0005
`define FSPC_CFG_DEV_ID     15'h0006
`define FSPC_CFG_WORD1      15'h0007
`define FSPC_CFG_WORD2      15'h0008
`define FSPC_PROG_TIME_NS   2000000
`define FSPC_ERASE_TIME_NS  2000000
`define FSPC_CLK_NS         5
`endif

// *** rtl/fspc_pkg.sv ***
// Types for the flash self-program control block.
// Assumes fspc_cfg.svh is available for constants.
package fspc_pkg;
    typedef enum logic [1:0] {
        FSPC_IDLE,
        FSPC_LOAD,
        FSPC_PROG,
        FSPC_ERASE
    } fspc_state_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } fspc_wb_req_t;
endpackage : fspc_pkg

// *** rtl/fspc_top.sv ***
// Flash self-program control: register file and sequencer for main
// flash, its write latches and a small configuration region.
// Assumes a single-cycle Wishbone master on the same clock.
// Functional notes
// - Config select redirects access to config region.
// - Illegal config read clears both data registers.
// - User ID words readable and writable.
// - Device and revision IDs read-only.
// - Configuration words are never written here.
// - Word split into low byte, six-bit high.
// - Address split; high bit seven reads one.
// - Latch-only loads latch; else load and program.
// - Erase select erases row, cleared when done.
// - Latch-only ignored while erase selected.
// - Fault set on go, cleared on completion.
// - Program enable clear inhibits program and erase.
// - Go starts timed operation; hardware clears.
// - Fetch-go reads in one cycle, self clears.
// - Unlock pair 55h then AAh required.
// - Interrupted unlock refuses any write.
// - Latches return blank after program or erase.
// - Upper bits pick row, low four latch.
`timescale 1ns/1ps
`include "fspc_cfg.svh"

module fspc_top #(
    parameter int ADDR_W    = 15,
    parameter int LATCHES   = 16,
    parameter int PROG_CYC  = `FSPC_PROG_TIME_NS / `FSPC_CLK_NS,
    parameter int ERASE_CYC = `FSPC_ERASE_TIME_NS / `FSPC_CLK_NS,
    parameter logic [13:0] DEV_ID   = 14'h0123, // Arbitrary value.
    parameter logic [13:0] REV_ID   = 14'h0001  // Arbitrary value.
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    output logic             wb_err_o,
    output logic             busy_o
);
    localparam int LW = $clog2(LATCHES);
    localparam int CW = 24;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    // The array and config words are modelled here. A real part would
    // reach them through its own macro interface.
    logic [13:0] flash_mem [0:(1<<ADDR_W)-1];
    logic [13:0] latch     [0:LATCHES-1];
    logic [13:0] user_id   [0:3];
    logic [13:0] cfg_word  [0:1];

    fspc_pkg::fspc_state_t state;
    fspc_pkg::fspc_wb_req_t req;
    logic [7:0]        data_low;
    logic [5:0]        data_high;
    logic [7:0]        addr_low;
    logic [6:0]        addr_high;
    logic              cfg_sel, latch_only, erase_sel, fault, prog_en;
    logic              prog_go, fetch_go;
    logic [1:0]        key_stage;
    logic [CW-1:0]     timer;
    logic [ADDR_W-1:0] op_addr;
    logic              op_cfg;

    assign req = '{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i,
                   wb_dat_i};

    // Full word address, high byte above low byte.
    wire [ADDR_W-1:0] word_addr = {addr_high, addr_low};
    wire wr_req = req.cyc && req.stb && req.we && !wb_ack_o;
    wire rd_req = req.cyc && req.stb && !req.we && !wb_ack_o;
    wire lane0  = req.sel[0];
    wire [7:0] wbyte = req.dat[7:0];

    // Decodes whether a bus offset is one of ours.
    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == `FSPC_OFF_DATA_LOW) || (a == `FSPC_OFF_DATA_HIGH)
              || (a == `FSPC_OFF_ADDR_LOW) || (a == `FSPC_OFF_ADDR_HIGH)
              || (a == `FSPC_OFF_CONTROL)  || (a == `FSPC_OFF_UNLOCK);
    endfunction : mapped

    function automatic logic is_reg(input logic [7:0] a,
                                    input logic [7:0] off);
        is_reg = (a == off);
    endfunction : is_reg

    wire ctl_wr = wr_req && lane0 && is_reg(req.adr, `FSPC_OFF_CONTROL);
    wire key_wr = wr_req && lane0 && is_reg(req.adr, `FSPC_OFF_UNLOCK);

    // Go is honoured only when armed by the key pair, writes enabled
    // and the sequencer is idle.
    wire go_try = ctl_wr && wbyte[`FSPC_BIT_PROG_GO];
    wire go_ok  = go_try && key_stage == 2'd2 && prog_en
                  && state == fspc_pkg::FSPC_IDLE;
    wire rd_go  = ctl_wr && wbyte[`FSPC_BIT_FETCH_GO]
                  && state == fspc_pkg::FSPC_IDLE;

    // ------------------------------------------------------------
    // Wishbone slave: one registered ack, errors on unmapped words.
    // ------------------------------------------------------------
    // Ack and err are registered, so every access costs two cycles. The
    // second cycle is kept out by the ack term in the request decode, or for an error by the wb_err_o term.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
        end else begin
            wb_ack_o <= (wr_req || rd_req) && mapped(req.adr);
            wb_err_o <= (wr_req || rd_req) && !mapped(req.adr)
                        && !wb_err_o;
        end
    end

    // Read mux; reserved bits read zero, except bit seven of address high and of control, which reads one.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (rd_req) begin
            unique case (req.adr)
                `FSPC_OFF_DATA_LOW:  wb_dat_o <= {24'h00_0000, data_low};
                `FSPC_OFF_DATA_HIGH: wb_dat_o <= {26'h000_0000,
                                                  data_high};
                `FSPC_OFF_ADDR_LOW:  wb_dat_o <= {24'h00_0000, addr_low};
                `FSPC_OFF_ADDR_HIGH: wb_dat_o <= {24'h00_0000, 1'b1,
                                                  addr_high};
                `FSPC_OFF_CONTROL:   wb_dat_o <= {24'h00_0000, 1'b1,
                    cfg_sel, latch_only, erase_sel, fault, prog_en,
                    prog_go, fetch_go};
                default:             wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Unlock key tracker: any other mapped access breaks the sequence.
    // ------------------------------------------------------------
    // The go write is itself a mapped access, so it disarms the key as
    // well; every operation needs a fresh pair.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            key_stage <= 2'd0;
        end else if (key_wr) begin
            key_stage <= (wbyte == `FSPC_KEY_FIRST)  ? 2'd1 :
                         (wbyte == `FSPC_KEY_SECOND && key_stage == 2'd1)
                         ? 2'd2 : 2'd0;
        end else if ((wr_req || rd_req) && mapped(req.adr)) begin
            key_stage <= 2'd0;
        end
    end

    // ------------------------------------------------------------
    // Address registers and plain control bits.
    // ------------------------------------------------------------
    // Only byte lane zero carries register data; other lanes are ignored.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            addr_low   <= 8'h00;
            addr_high  <= 7'h00;
            cfg_sel    <= 1'b0;
            latch_only <= 1'b0;
            prog_en    <= 1'b0;
        end else if (wr_req && lane0) begin
            if (is_reg(req.adr, `FSPC_OFF_ADDR_LOW))  addr_low  <= wbyte;
            if (is_reg(req.adr, `FSPC_OFF_ADDR_HIGH)) addr_high <= wbyte[6:0];
            if (ctl_wr) begin
                cfg_sel    <= wbyte[`FSPC_BIT_CFG_SEL];
                latch_only <= wbyte[`FSPC_BIT_LATCH_ONLY];
                prog_en    <= wbyte[`FSPC_BIT_PROG_EN];
            end
        end
    end

    // Erase select: software writes it, hardware clears at erase end.
    // A control write in the very cycle the erase ends is kept, so a
    // new erase request is never lost to the hardware clear.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            erase_sel <= 1'b0;
        end else if (ctl_wr) begin
            erase_sel <= wbyte[`FSPC_BIT_ERASE_SEL];
        end else if (state == fspc_pkg::FSPC_ERASE && timer == '0) begin
            erase_sel <= 1'b0;
        end
    end

    // Fault: any attempt to set go raises it; a normal finish clears
    // it. The attempt wins because it is checked last.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fault <= 1'b0;
        end else begin
            if (state != fspc_pkg::FSPC_IDLE && timer == '0)
                fault <= 1'b0;
            else if (ctl_wr && !go_try)
                fault <= wbyte[`FSPC_BIT_FAULT];
            if (go_try)
                fault <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Sequencer: go bit, self-timed program and erase.
    // ------------------------------------------------------------
    // The timer counts down to zero; the cycle at zero is the last cycle out of idle
    // (busy_o stays high one cycle longer) and the one in which the array and latches are updated.
    // A latch-only load starts at zero and so lasts a single cycle.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state   <= fspc_pkg::FSPC_IDLE;
            prog_go <= 1'b0;
            timer   <= '0;
            op_addr <= '0;
            op_cfg  <= 1'b0;
        end else begin
            unique case (state)
                fspc_pkg::FSPC_IDLE: if (go_ok) begin
                    prog_go <= 1'b1;
                    op_addr <= word_addr;
                    op_cfg  <= cfg_sel;
                    if (erase_sel) begin
                        state <= fspc_pkg::FSPC_ERASE;
                        timer <= CW'(ERASE_CYC - 1);
                    end else if (latch_only) begin
                        state <= fspc_pkg::FSPC_LOAD;
                        timer <= '0;
                    end else begin
                        state <= fspc_pkg::FSPC_PROG;
                        timer <= CW'(PROG_CYC - 1);
                    end
                end
                fspc_pkg::FSPC_LOAD, fspc_pkg::FSPC_PROG,
                fspc_pkg::FSPC_ERASE: begin
                    if (timer == '0) begin
                        state   <= fspc_pkg::FSPC_IDLE;
                        prog_go <= 1'b0;
                    end else begin
                        timer <= timer - 1'b1;
                    end
                end
            endcase
        end
    end

    // Busy covers the cycle in which go is taken, so software polling
    // right after its go write never sees a false idle.
    always_ff @(posedge clk_i) begin
        if (rst_i) busy_o <= 1'b0;
        else       busy_o <= (state != fspc_pkg::FSPC_IDLE) || go_ok;
    end

    // ------------------------------------------------------------
    // Latches and arrays. Loads happen on the go edge; a program or erase
    // writes the array on completion, then all latches return to blank.
    // ------------------------------------------------------------
    wire [LW-1:0] lsel = word_addr[LW-1:0];
    wire done = state != fspc_pkg::FSPC_IDLE && timer == '0;
    wire [ADDR_W-1:0] row_base = {op_addr[ADDR_W-1:LW], {LW{1'b0}}};

    // One process per latch keeps each load enable simple. The blank
    // reset outranks a load so no stale word survives an operation.
    for (genvar g = 0; g < LATCHES; g++) begin : g_latch
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                latch[g] <= `FSPC_BLANK_WORD;
            end else if (done && state != fspc_pkg::FSPC_LOAD) begin
                latch[g] <= `FSPC_BLANK_WORD;
            end else if (go_ok && !erase_sel && lsel == LW'(g)) begin
                latch[g] <= {data_high, data_low};
            end
        end
    end

    // Array update for the addressed row only; never crosses rows.
    // The array has no reset: flash contents survive a device reset.
    always_ff @(posedge clk_i) begin
        if (done && !op_cfg) begin
            for (int i = 0; i < LATCHES; i++) begin
                if (state == fspc_pkg::FSPC_ERASE)
                    flash_mem[row_base | ADDR_W'(i)] <= `FSPC_BLANK_WORD;
                else if (state == fspc_pkg::FSPC_PROG)
                    flash_mem[row_base | ADDR_W'(i)] <= latch[i];
            end
        end
    end

    // Config region: only user IDs take a program; IDs and config
    // words are left alone by design.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < 4; i++) user_id[i] <= `FSPC_BLANK_WORD;
            for (int i = 0; i < 2; i++) cfg_word[i] <= `FSPC_BLANK_WORD;
        end else if (done && op_cfg
                     && state == fspc_pkg::FSPC_PROG) begin
            for (int i = 0; i < 4; i++)
                user_id[i] <= latch[i];
        end
    end

    // ------------------------------------------------------------
    // Fetch-go and data registers.
    // ------------------------------------------------------------
    // Config-space read decode. Holes in the region read as zero.
    function automatic logic [13:0] cfg_read(input logic [ADDR_W-1:0] a);
        if (a <= `FSPC_CFG_USER_LAST)  cfg_read = user_id[a[1:0]];
        else if (a == `FSPC_CFG_REV_ID) cfg_read = REV_ID;
        else if (a == `FSPC_CFG_DEV_ID) cfg_read = DEV_ID;
        else if (a == `FSPC_CFG_WORD1)  cfg_read = cfg_word[0];
        else if (a == `FSPC_CFG_WORD2)  cfg_read = cfg_word[1];
        else                            cfg_read = 14'h0000;
    endfunction : cfg_read

    wire [13:0] rd_word = cfg_sel ? cfg_read(word_addr)
                                  : flash_mem[word_addr];

    // Fetch-go is a one-cycle pulse. Software can set it but never
    // clear it; it only ever falls by itself.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fetch_go <= 1'b0;
        end else begin
            fetch_go <= rd_go;
        end
    end

    // A fetch outranks a bus write to the data registers. Both cannot
    // fall in one cycle anyway, as one access is taken at a time.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            data_low  <= 8'h00;
            data_high <= 6'h00;
        end else if (rd_go) begin
            data_low  <= rd_word[7:0];
            data_high <= rd_word[13:8];
        end else if (wr_req && lane0) begin
            if (is_reg(req.adr, `FSPC_OFF_DATA_LOW))  data_low  <= wbyte;
            if (is_reg(req.adr, `FSPC_OFF_DATA_HIGH)) data_high <= wbyte[5:0];
        end
    end
endmodule : fspc_top

// *** sim/fspc_monitor.sv ***
// Checker for the flash self-program control register port.
// Assumes it is bound to fspc_top and sees only that module's ports.
`timescale 1ns/1ps
module fspc_monitor #(
    parameter int PROG_CYC = 8
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        wb_err_o,
    input wire logic        busy_o
);
    // ------------------------------------------------------------
    // Helper state and properties
    // ------------------------------------------------------------
    localparam int BUSY_MAX = PROG_CYC + 2;
    logic [15:0] busy_cnt;
    logic        en_seen;
    logic [1:0]  key_seen;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // A counter bounds long busy runs without a deep repetition.
    always_ff @(posedge clk_i) begin
        if (rst_i || !busy_o) begin
            busy_cnt <= 16'h0000;
        end else begin
            busy_cnt <= busy_cnt + 16'h0001;
        end
    end
    // Tracks the enable bit from the last accepted control write.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_seen <= 1'b0;
        end else if (wb_ack_o && wb_we_i && wb_adr_i == 8'h10) begin
            en_seen <= wb_dat_i[2];
        end
    end
    // Follows the unlock pair as the slave acks it; any other acked access
    // in between disarms it.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            key_seen <= 2'd0;
        end else if (wb_ack_o) begin
            if (wb_we_i && wb_adr_i == 8'h14 && wb_dat_i[7:0] == 8'h55)
                key_seen <= 2'd1;
            else if (wb_we_i && wb_adr_i == 8'h14 && key_seen == 2'd1
                     && wb_dat_i[7:0] == 8'hAA)
                key_seen <= 2'd2;
            else
                key_seen <= 2'd0;
        end
    end
    chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o &&
        !wb_err_o |=> wb_ack_o || wb_err_o) else $error("no answer");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack too long");
    chk_err_pulse: assert property (wb_err_o |=> !wb_err_o)
        else $error("err too long");
    chk_ack_err_excl: assert property (!(wb_ack_o && wb_err_o))
        else $error("ack with err");
    chk_dhigh_upper: assert property (wb_ack_o && !wb_we_i &&
        wb_adr_i == 8'h04 |-> wb_dat_o[31:6] == 26'h000_0000)
        else $error("data high upper bits set");
    chk_ahigh_bit7: assert property (wb_ack_o && !wb_we_i &&
        wb_adr_i == 8'h0C |-> wb_dat_o[31:7] == 25'h000_0001)
        else $error("address high bit 7 wrong");
    chk_busy_keyed: assert property ($rose(busy_o) |->
        key_seen == 2'd2) else $error("busy without unlock pair");
    chk_busy_cause: assert property ($rose(busy_o) |->
        $past(wb_we_i && wb_adr_i == 8'h10, 1) ||
        $past(wb_we_i && wb_adr_i == 8'h10, 2))
        else $error("busy without go write");
    chk_busy_enable: assert property ($rose(busy_o) |-> en_seen)
        else $error("busy while writes disabled");
    chk_busy_bound: assert property (busy_cnt <= BUSY_MAX)
        else $error("operation overran");
    cov_busy: cover property ($rose(busy_o));
    cov_err: cover property (wb_err_o);
    cov_dhigh: cover property (wb_ack_o && !wb_we_i && wb_adr_i == 8'h04);
endmodule : fspc_monitor

bind fspc_top fspc_monitor #(.PROG_CYC(PROG_CYC)) u_mon (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .busy_o(busy_o));

// *** sim/fspc_wb_master.sv ***
// Software side model: a classic Wishbone master, one cycle at a time.
// Assumes the slave answers with ack or err on the same clock.
`timescale 1ns/1ps
module fspc_wb_master (
    input  wire logic              clk_i,
    input  wire logic              ack_i,
    input  wire logic              err_i,
    input  wire logic [31:0]       dat_i,
    output fspc_pkg::fspc_wb_req_t req_o
);
    // ------------------------------------------------------------
    // Bus cycle
    // ------------------------------------------------------------
    initial req_o = '0;
    // Holds the whole request until the answer is sampled, so a slow
    // slave sees no change mid-cycle.
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [7:0] d, output logic [31:0] q,
                        output logic e);
        @(posedge clk_i);
        req_o <= '{1'b1, 1'b1, w, a, 4'h1, {24'h00_0000, d}};
        do @(posedge clk_i); while (!(ack_i || err_i));
        q = dat_i;
        e = err_i;
        req_o <= '0;
    endtask : xfer
endmodule : fspc_wb_master

// *** sim/flash_self_program_control_tb_top.sv ***
// Self-checking bench for the flash self-program control block.
// Assumes short program and erase counts so the run stays brief.
`timescale 1ns/1ps
module flash_self_program_control_tb_top;
    // ------------------------------------------------------------
    // Harness
    // ------------------------------------------------------------
    localparam logic [13:0] DEV = 14'h0A5C; // Arbitrary value.
    localparam logic [13:0] REV = 14'h0007; // Arbitrary value.
    logic                   clk_i = 1'b0;
    logic                   rst_i = 1'b1;
    fspc_pkg::fspc_wb_req_t req;
    logic [31:0]            dat_o;
    logic                   ack;
    logic                   err;
    logic                   busy;
    logic [31:0]            q;
    logic                   e;
    int                     n_fail = 0;
    int                     n_compared = 0;
    fspc_top #(.PROG_CYC(8), .ERASE_CYC(8), .DEV_ID(DEV), .REV_ID(REV))
    uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req.cyc),
         .wb_stb_i(req.stb), .wb_we_i(req.we), .wb_adr_i(req.adr),
         .wb_sel_i(req.sel), .wb_dat_i(req.dat), .wb_dat_o(dat_o),
         .wb_ack_o(ack), .wb_err_o(err), .busy_o(busy));
    fspc_wb_master bfm (.clk_i(clk_i), .ack_i(ack), .err_i(err),
                        .dat_i(dat_o), .req_o(req));
    // The clock toggles every half period of 2.5 ns.
    initial forever #2.5 clk_i = ~clk_i;
    task automatic final_report();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : final_report
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        bfm.xfer(1'b1, a, d, q, e);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        bfm.xfer(1'b0, a, 8'h00, q, e);
    endtask : rd
    // Fetches one word and compares both data bytes.
    task automatic rd_word(input logic [14:0] a, input logic [7:0] c,
                           input logic [13:0] w);
        wr(8'h08, a[7:0]);
        wr(8'h0C, {1'b0, a[14:8]});
        wr(8'h10, c & 8'hFE);
        wr(8'h10, c);
        rd(8'h00);
        chk(q, {24'h00_0000, w[7:0]});
        rd(8'h04);
        chk(q, {26'h000_0000, w[13:8]});
    endtask : rd_word
    // Key mode 0 skips the key, 1 is proper, 2 breaks it mid-pair.
    task automatic go(input logic [14:0] a, input logic [13:0] w,
                      input logic [7:0] c, input int k);
        wr(8'h08, a[7:0]);
        wr(8'h0C, {1'b0, a[14:8]});
        wr(8'h00, w[7:0]);
        wr(8'h04, {2'b00, w[13:8]});
        wr(8'h10, c & 8'hFD);
        if (k != 0) wr(8'h14, 8'h55);
        if (k == 2) wr(8'h08, a[7:0]);
        if (k != 0) wr(8'h14, 8'hAA);
        wr(8'h10, c);
        @(negedge clk_i);
        chk({31'h0, busy}, {31'h0, k == 1 && c[2]});
        repeat (2) @(posedge clk_i);
        for (int i = 0; i < 40 && busy !== 1'b0; i++) @(posedge clk_i);
        chk({31'h0, busy}, 32'h0000_0000);
    endtask : go
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        rd(8'h08);
        chk(q, 32'h0000_0000);
        rd(8'h0C);
        chk(q, 32'h0000_0080);
        rd(8'h10);
        chk(q, 32'h0000_0080);
        wr(8'h04, 8'hFF);
        rd(8'h04);
        chk(q, 32'h0000_003F);
        rd(8'h18);
        chk({31'h0000_0000, e}, 32'h0000_0001);
    endtask : t_regs
    task automatic t_row();
        go(15'h0010, 14'h01A5, 8'h26, 1);
        go(15'h0013, 14'h02C3, 8'h06, 1);
        rd(8'h10);
        chk(q, 32'h0000_0084);
        rd_word(15'h0010, 8'h05, 14'h01A5);
        rd_word(15'h0013, 8'h05, 14'h02C3);
        rd_word(15'h0012, 8'h05, 14'h3FFF);
    endtask : t_row
    // Erase with latch-only set, then rewrite and verify one word of the row.
    task automatic t_modify();
        go(15'h0010, 14'h0000, 8'h36, 1);
        rd(8'h10);
        chk(q, 32'h0000_00A4);
        rd_word(15'h0013, 8'h05, 14'h3FFF);
        go(15'h0011, 14'h0ABC, 8'h06, 1);
        rd_word(15'h0011, 8'h05, 14'h0ABC);
    endtask : t_modify
    task automatic t_refuse();
        int k[3] = '{0, 2, 1};
        for (int m = 0; m < 3; m++) begin
            go(15'h0012, 14'h0111, (m == 2) ? 8'h02 : 8'h06, k[m]);
            rd(8'h10);
            chk(q & 32'h0000_000A, 32'h0000_0008);
            rd_word(15'h0012, 8'h05, 14'h3FFF);
        end
    endtask : t_refuse
    task automatic t_cfg();
        go(15'h0002, 14'h1234, 8'h46, 1);
        rd_word(15'h0002, 8'h45, 14'h1234);
        go(15'h0006, 14'h0000, 8'h46, 1);
        rd_word(15'h0006, 8'h45, DEV);
        rd_word(15'h0005, 8'h45, REV);
        go(15'h0007, 14'h0000, 8'h46, 1);
        rd_word(15'h0007, 8'h45, 14'h3FFF);
        rd_word(15'h0004, 8'h45, 14'h0000);
    endtask : t_cfg
    // Watchdog far beyond the expected several hundred cycles.
    initial begin
        #250000;
        n_fail++;
        final_report();
    end
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_row();
        t_modify();
        t_refuse();
        t_cfg();
        final_report();
    end
endmodule : flash_self_program_control_tb_top
